// ---- hdl/cdd_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdd_exec (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire cdd_pkg::cdd_req_s req,
    output logic                   ready,
    output logic                   done,
    output logic                   illegal,
    output cdd_pkg::cdd_res_s      res,
    output logic                   stk_we,
    output logic                   stk_re,
    output logic [15:0]            stk_addr,
    output logic [15:0]            stk_wdata,
    input  wire logic [15:0]       stk_rdata,
    output logic [15:0]            prog_addr,
    input  wire logic [15:0]       prog_data,
    input  wire logic              irq_pend,
    output logic                   irq_enable,
    output logic                   irq_service
);
    typedef struct packed {
        cdd_pkg::cdd_state_e st;
        logic [4:0]          cnt;
        cdd_pkg::cdd_req_s   req;
        cdd_pkg::cdd_res_s   res;
        logic                done;
        logic                illegal;
        logic                stk_we;
        logic                stk_re;
        logic [15:0]         stk_addr;
        logic [15:0]         stk_wdata;
        logic [15:0]         prog_addr;
        logic [15:0]         popped;
        logic                irq_en;
    } cdd_exec_s;

    cdd_exec_s   q_ff;
    cdd_exec_s   nxt_q;
    logic        dv_start;
    logic        dv_done;
    logic [15:0] dv_quo;
    logic [7:0]  dv_rem;

    function automatic logic is_div(input logic [7:0] op);
        return op == cdd_pkg::OP_DIV_R || op == cdd_pkg::OP_DIV_IR || op == cdd_pkg::OP_DIV_IM;
    endfunction

    function automatic logic is_cdb(input logic [7:0] op);
        return op[3:0] == cdd_pkg::OP_CDB_NIB;
    endfunction

    function automatic logic [4:0] cyc_of(input cdd_pkg::cdd_req_s r);
        logic [4:0] c;
        c = cdd_pkg::CYC_ILLEGAL;
        if (is_cdb(r.opcode)) begin
            c = cdd_pkg::CYC_CDB;
        end else if (is_div(r.opcode)) begin
            c = (r.src == 8'h00) ? cdd_pkg::CYC_DIV_ZERO : cdd_pkg::CYC_DIV;
        end else begin
            unique case (r.opcode)
                cdd_pkg::OP_BMO_R, cdd_pkg::OP_BMO_IR: c = cdd_pkg::CYC_BMO;
                cdd_pkg::OP_WMO_RR, cdd_pkg::OP_WMO_IR: c = cdd_pkg::CYC_WMO;
                cdd_pkg::OP_IRQ_OFF, cdd_pkg::OP_IRQ_ON: c = cdd_pkg::CYC_IRQ;
                cdd_pkg::OP_ENTER: c = cdd_pkg::CYC_ENTER;
                cdd_pkg::OP_EXIT: c = r.stk_ext ? cdd_pkg::CYC_EXIT_EXT : cdd_pkg::CYC_EXIT_INT;
                default: c = cdd_pkg::CYC_ILLEGAL;
            endcase
        end
        return c;
    endfunction

    always_comb begin
        logic [7:0]  r8;
        logic [15:0] r16;
        logic [7:0]  f;
        cdd_pkg::cdd_req_s rq;
        rq    = q_ff.req;
        r8    = 8'(rq.dst[7:0] - 8'h01);
        r16   = 16'(rq.dst - 16'h0001);
        f     = rq.ctx.flags;
        nxt_q = q_ff;
        dv_start             = 1'b0;
        nxt_q.done           = 1'b0;
        nxt_q.illegal        = 1'b0;
        nxt_q.stk_we         = 1'b0;
        nxt_q.stk_re         = 1'b0;
        nxt_q.res.dst8_we    = 1'b0;
        nxt_q.res.dst16_we   = 1'b0;
        nxt_q.res.flags_we   = 1'b0;
        nxt_q.res.pc_we      = 1'b0;
        nxt_q.res.sp_we      = 1'b0;
        nxt_q.res.tp_we      = 1'b0;
        unique case (q_ff.st)
            cdd_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_q.req = req;
                    nxt_q.st  = cdd_pkg::ST_RUN;
                    nxt_q.cnt = 5'(cyc_of(req) - 5'd1);
                    dv_start  = is_div(req.opcode) && req.src != 8'h00;
                    if (req.opcode == cdd_pkg::OP_ENTER) begin
                        nxt_q.stk_we    = 1'b1;
                        nxt_q.stk_addr  = 16'(req.ctx.sp - cdd_pkg::WORD_STEP);
                        nxt_q.stk_wdata = req.ctx.tp;
                        nxt_q.prog_addr = req.ctx.pc;
                    end
                    if (req.opcode == cdd_pkg::OP_EXIT) begin
                        nxt_q.stk_re   = 1'b1;
                        nxt_q.stk_addr = req.ctx.sp;
                    end
                end
            end
            cdd_pkg::ST_RUN: begin
                nxt_q.cnt = 5'(q_ff.cnt - 5'd1);
                if (rq.opcode == cdd_pkg::OP_EXIT && q_ff.cnt == cdd_pkg::CNT_EXIT_POP) begin
                    nxt_q.popped    = stk_rdata;
                    nxt_q.prog_addr = stk_rdata;
                end
                if (q_ff.cnt == cdd_pkg::CNT_LAST) begin
                    nxt_q.st        = cdd_pkg::ST_IDLE;
                    nxt_q.done      = 1'b1;
                    nxt_q.res.dst   = rq.dst;
                    nxt_q.res.wreg  = rq.opcode[7:4];
                    nxt_q.res.pc    = rq.ctx.pc;
                    nxt_q.res.sp    = rq.ctx.sp;
                    nxt_q.res.tp    = rq.ctx.tp;
                    nxt_q.res.len   = cdd_pkg::LEN_ONE;
                    if (is_cdb(rq.opcode)) begin
                        nxt_q.res.dst     = {rq.dst[15:8], r8};
                        nxt_q.res.dst8_we = 1'b1;
                        nxt_q.res.len     = cdd_pkg::LEN_TWO;
                        if (r8 != 8'h00) begin
                            nxt_q.res.pc    = 16'(rq.ctx.pc + {{8{rq.disp[7]}}, rq.disp});
                            nxt_q.res.pc_we = 1'b1;
                        end
                    end else if (is_div(rq.opcode)) begin
                        nxt_q.res.len = cdd_pkg::LEN_THREE;
                        nxt_q.res.flags_we = 1'b1;
                        if (rq.src == 8'h00) begin
                            f[cdd_pkg::FLG_V] = 1'b1;
                            f[cdd_pkg::FLG_C] = 1'b0;
                            f[cdd_pkg::FLG_Z] = 1'b1;
                            f[cdd_pkg::FLG_S] = 1'b0;
                        end else begin
                            nxt_q.res.dst      = {dv_rem, dv_quo[7:0]};
                            nxt_q.res.dst16_we = 1'b1;
                            // overflow and carry from quotient range
                            f[cdd_pkg::FLG_V] = |dv_quo[15:8];
                            f[cdd_pkg::FLG_C] = (|dv_quo[15:8]) && dv_quo[15:9] == 7'h00;
                            f[cdd_pkg::FLG_Z] = dv_quo == 16'h0000;
                            f[cdd_pkg::FLG_S] = dv_quo[7];
                        end
                    end else begin
                        unique case (rq.opcode)
                            cdd_pkg::OP_BMO_R, cdd_pkg::OP_BMO_IR: begin
                                nxt_q.res.dst      = {rq.dst[15:8], r8};
                                nxt_q.res.dst8_we  = 1'b1;
                                nxt_q.res.len      = cdd_pkg::LEN_TWO;
                                f[cdd_pkg::FLG_Z]  = r8 == 8'h00;
                                f[cdd_pkg::FLG_S]  = r8[7];
                                f[cdd_pkg::FLG_V]  = rq.dst[7:0] == cdd_pkg::BYTE_MIN_NEG;
                                nxt_q.res.flags_we = 1'b1;
                            end
                            cdd_pkg::OP_WMO_RR, cdd_pkg::OP_WMO_IR: begin
                                // word minus one, one 16-bit subtract with the low byte borrow carried into the high byte
                                nxt_q.res.dst      = r16;
                                nxt_q.res.dst16_we = 1'b1;
                                nxt_q.res.len      = cdd_pkg::LEN_TWO;
                                f[cdd_pkg::FLG_Z]  = r16 == 16'h0000;
                                f[cdd_pkg::FLG_S]  = r16[15];
                                f[cdd_pkg::FLG_V]  = rq.dst == cdd_pkg::WORD_MIN_NEG;
                                nxt_q.res.flags_we = 1'b1;
                            end
                            cdd_pkg::OP_IRQ_OFF: nxt_q.irq_en = 1'b0;
                            cdd_pkg::OP_IRQ_ON: nxt_q.irq_en = 1'b1;
                            cdd_pkg::OP_ENTER: begin
                                nxt_q.res.sp    = 16'(rq.ctx.sp - cdd_pkg::WORD_STEP);
                                nxt_q.res.tp    = 16'(rq.ctx.pc + cdd_pkg::WORD_STEP);
                                nxt_q.res.pc    = prog_data;
                                nxt_q.res.sp_we = 1'b1;
                                nxt_q.res.tp_we = 1'b1;
                                nxt_q.res.pc_we = 1'b1;
                            end
                            cdd_pkg::OP_EXIT: begin
                                nxt_q.res.sp    = 16'(rq.ctx.sp + cdd_pkg::WORD_STEP);
                                nxt_q.res.tp    = 16'(q_ff.popped + cdd_pkg::WORD_STEP);
                                nxt_q.res.pc    = prog_data;
                                nxt_q.res.sp_we = 1'b1;
                                nxt_q.res.tp_we = 1'b1;
                                nxt_q.res.pc_we = 1'b1;
                            end
                            default: nxt_q.illegal = 1'b1;
                        endcase
                    end
                    nxt_q.res.flags = f;
                end
            end
            default: nxt_q.st = cdd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q_ff        <= '0;
            q_ff.st     <= cdd_pkg::ST_IDLE;
            q_ff.irq_en <= cdd_pkg::MODE_IRQ_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    cdd_divider u_div (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .start    (dv_start),
        .dividend (req.dst),
        .divisor  (req.src),
        .done     (dv_done),
        .quo      (dv_quo),
        .rem      (dv_rem)
    );

    assign ready      = q_ff.st == cdd_pkg::ST_IDLE;
    assign done       = q_ff.done;
    assign illegal    = q_ff.illegal;
    assign res        = q_ff.res;
    assign stk_we     = q_ff.stk_we;
    assign stk_re     = q_ff.stk_re;
    assign stk_addr   = q_ff.stk_addr;
    assign stk_wdata  = q_ff.stk_wdata;
    assign prog_addr  = q_ff.prog_addr;
    assign irq_enable = q_ff.irq_en;
    assign irq_service = q_ff.irq_en && irq_pend;

    logic take;
    assign take = ready && start;

    a_byte_dec_time: assert property (@(posedge ref_clk) disable iff (rst)
        (take && req.opcode == cdd_pkg::OP_BMO_R) |-> ##1 (!done)[*3] ##1 (done && res.dst8_we))
        else $error("byte decrement timing wrong");
    a_byte_dec_flags: assert property (@(posedge ref_clk) disable iff (rst)
        (done && q_ff.res.dst8_we && !is_cdb(q_ff.req.opcode)) |->
            (res.flags[cdd_pkg::FLG_Z] == (res.dst[7:0] == 8'h00)
            && res.flags[cdd_pkg::FLG_C] == q_ff.req.ctx.flags[cdd_pkg::FLG_C]
            && res.dst[7:0] == 8'(q_ff.req.dst[7:0] - 8'h01)))
        else $error("byte decrement result or flags wrong");
    a_word_dec_time: assert property (@(posedge ref_clk) disable iff (rst)
        (take && req.opcode == cdd_pkg::OP_WMO_RR) |-> ##8 (done && res.dst16_we
            && res.dst == 16'($past(req.dst, 8) - 16'h0001)))
        else $error("word decrement wrong");
    a_word_dec_flags: assert property (@(posedge ref_clk) disable iff (rst)
        (done && q_ff.res.dst16_we && !is_div(q_ff.req.opcode)) |->
            (res.flags[cdd_pkg::FLG_S] == res.dst[15] && res.flags[cdd_pkg::FLG_V] == (res.dst == 16'h7fff)))
        else $error("word decrement flags wrong");
    a_irq_off_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (take && req.opcode == cdd_pkg::OP_IRQ_OFF) |-> ##4 (done && !irq_enable && !irq_service))
        else $error("interrupt off did not gate servicing");
    a_irq_on_serve: assert property (@(posedge ref_clk) disable iff (rst)
        (take && req.opcode == cdd_pkg::OP_IRQ_ON) |-> ##4 (irq_enable && (irq_service == irq_pend)))
        else $error("interrupt on did not enable servicing");
    a_pending_served: assert property (@(posedge ref_clk) disable iff (rst)
        (irq_enable && irq_pend) |-> irq_service)
        else $error("pending request not serviced while enabled");
    a_div_zero_time: assert property (@(posedge ref_clk) disable iff (rst)
        (take && is_div(req.opcode) && req.src == 8'h00) |-> ##10 (done && res.flags[cdd_pkg::FLG_V]
            && res.flags[cdd_pkg::FLG_Z] && !res.dst16_we))
        else $error("zero divisor handling wrong");
    a_div_flags_ovf: assert property (@(posedge ref_clk) disable iff (rst)
        (take && is_div(req.opcode) && req.src != 8'h00) |-> ##26 (done && res.len == cdd_pkg::LEN_THREE
            && res.flags[cdd_pkg::FLG_V] == ($past(req.dst, 26) / {8'h00, $past(req.src, 26)} > 16'h00ff)))
        else $error("divide overflow flag or timing wrong");
    a_cdb_target: assert property (@(posedge ref_clk) disable iff (rst)
        (take && is_cdb(req.opcode)) |-> ##8 (done && (res.pc_we == (res.dst[7:0] != 8'h00))
            && res.flags == $past(req.ctx.flags, 8)))
        else $error("count-down branch wrong");
    a_enter_ptrs: assert property (@(posedge ref_clk) disable iff (rst)
        (take && req.opcode == cdd_pkg::OP_ENTER) |-> ##1 (stk_we && stk_wdata == $past(req.ctx.tp))
            ##13 (done && res.tp == 16'($past(req.ctx.pc, 14) + cdd_pkg::WORD_STEP) && res.pc == $past(prog_data)))
        else $error("enter pointer handling wrong");
    a_flags_kept: assert property (@(posedge ref_clk) disable iff (rst)
        (done && (q_ff.req.opcode == cdd_pkg::OP_IRQ_ON || q_ff.req.opcode == cdd_pkg::OP_IRQ_OFF
            || q_ff.req.opcode == cdd_pkg::OP_ENTER || q_ff.req.opcode == cdd_pkg::OP_EXIT))
            |-> (!res.flags_we && res.flags == q_ff.req.ctx.flags))
        else $error("flags changed by flag-neutral instruction");
    a_exit_pop_addr: assert property (@(posedge ref_clk) disable iff (rst)
        (take && req.opcode == cdd_pkg::OP_EXIT) |-> ##1 (stk_re && stk_addr == $past(req.ctx.sp)))
        else $error("exit pop address wrong");
    a_div_quo_ready: assert property (@(posedge ref_clk) disable iff (rst)
        (take && is_div(req.opcode) && req.src != 8'h00) |-> ##17 dv_done)
        else $error("divider not finished in time");

endmodule
`default_nettype wire

// ---- hdl/cdd_pkg.sv ----
`default_nettype none
package cdd_pkg;

    // opcodes
    localparam logic [7:0] OP_BMO_R    = 8'h00;
    localparam logic [7:0] OP_BMO_IR   = 8'h01;
    localparam logic [7:0] OP_WMO_RR   = 8'h80;
    localparam logic [7:0] OP_WMO_IR   = 8'h81;
    localparam logic [7:0] OP_IRQ_OFF  = 8'h8f;
    localparam logic [7:0] OP_IRQ_ON   = 8'h9f;
    localparam logic [7:0] OP_DIV_R    = 8'h94;
    localparam logic [7:0] OP_DIV_IR   = 8'h95;
    localparam logic [7:0] OP_DIV_IM   = 8'h96;
    localparam logic [7:0] OP_ENTER    = 8'h1f;
    localparam logic [7:0] OP_EXIT     = 8'h2f;
    localparam logic [3:0] OP_CDB_NIB  = 4'ha;

    // cycle counts
    localparam logic [4:0] CYC_BMO      = 5'd4;
    localparam logic [4:0] CYC_WMO      = 5'd8;
    localparam logic [4:0] CYC_IRQ      = 5'd4;
    localparam logic [4:0] CYC_DIV      = 5'd26;
    localparam logic [4:0] CYC_DIV_ZERO = 5'd10;
    localparam logic [4:0] CYC_CDB      = 5'd8;
    localparam logic [4:0] CYC_ENTER    = 5'd14;
    localparam logic [4:0] CYC_EXIT_INT = 5'd14;
    localparam logic [4:0] CYC_EXIT_EXT = 5'd16;
    localparam logic [4:0] CYC_ILLEGAL  = 5'd2;
    localparam logic [4:0] CNT_LAST     = 5'd1;
    localparam logic [4:0] CNT_EXIT_POP = 5'd8;
    localparam logic [4:0] DIV_STEPS    = 5'd16;

    // instruction lengths in bytes
    localparam logic [1:0] LEN_ONE   = 2'd1;
    localparam logic [1:0] LEN_TWO   = 2'd2;
    localparam logic [1:0] LEN_THREE = 2'd3;

    // flag positions
    localparam int FLG_C = 7;
    localparam int FLG_Z = 6;
    localparam int FLG_S = 5;
    localparam int FLG_V = 4;

    localparam logic        MODE_IRQ_RST = 1'b0;
    localparam logic [15:0] WORD_STEP    = 16'h0002;
    localparam logic [7:0]  BYTE_MIN_NEG = 8'h80;
    localparam logic [15:0] WORD_MIN_NEG = 16'h8000;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] tp;
        logic [7:0]  flags;
    } cdd_ctx_s;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] dst;
        logic [7:0]  src;
        logic [7:0]  disp;
        logic        stk_ext;
        cdd_ctx_s    ctx;
    } cdd_req_s;

    typedef struct packed {
        logic [15:0] dst;
        logic        dst8_we;
        logic        dst16_we;
        logic [3:0]  wreg;
        logic [7:0]  flags;
        logic        flags_we;
        logic [15:0] pc;
        logic        pc_we;
        logic [15:0] sp;
        logic        sp_we;
        logic [15:0] tp;
        logic        tp_we;
        logic [1:0]  len;
    } cdd_res_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } cdd_state_e;

endpackage
`default_nettype wire

// ---- hdl/cdd_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
// restoring 16 by 8 unsigned divide, one quotient bit per cycle
module cdd_divider (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] dividend,
    input  wire logic [7:0]  divisor,
    output logic             done,
    output logic [15:0]      quo,
    output logic [7:0]       rem
);
    typedef struct packed {
        logic        busy;
        logic [4:0]  cnt;
        logic [7:0]  dvs;
        logic [7:0]  rem;
        logic [15:0] quo;
        logic        done;
    } cdd_div_s;

    cdd_div_s q_ff;
    cdd_div_s nxt_q;

    always_comb begin
        logic [8:0] part;
        part  = {q_ff.rem, q_ff.quo[15]};
        nxt_q = q_ff;
        nxt_q.done = 1'b0;
        if (start) begin
            nxt_q.busy = 1'b1;
            nxt_q.cnt  = cdd_pkg::DIV_STEPS;
            nxt_q.dvs  = divisor;
            nxt_q.rem  = 8'h00;
            nxt_q.quo  = dividend;
        end else if (q_ff.busy) begin
            if (part >= {1'b0, q_ff.dvs}) begin
                nxt_q.rem = 8'(part - {1'b0, q_ff.dvs});
                nxt_q.quo = {q_ff.quo[14:0], 1'b1};
            end else begin
                nxt_q.rem = part[7:0];
                nxt_q.quo = {q_ff.quo[14:0], 1'b0};
            end
            nxt_q.cnt = 5'(q_ff.cnt - 5'd1);
            if (q_ff.cnt == 5'd1) begin
                nxt_q.busy = 1'b0;
                nxt_q.done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign done = q_ff.done;
    assign quo  = q_ff.quo;
    assign rem  = q_ff.rem;

    a_div_result_exact: assert property (@(posedge ref_clk) disable iff (rst)
        (start && divisor != 8'h00) |-> ##17 (done && quo == $past(dividend, 17) / {8'h00, $past(divisor, 17)}
            && rem == 8'($past(dividend, 17) % {8'h00, $past(divisor, 17)})))
        else $error("divider result wrong");

endmodule
`default_nettype wire

// ---- verif/test_cpu_decrement_divide_interrupt_ops.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_cpu_decrement_divide_interrupt_ops;
    logic              ref_clk   = 1'b0;
    logic              rst       = 1'b1;
    logic              start     = 1'b0;
    logic              irq_pend  = 1'b0;
    logic [15:0]       stk_rdata = 16'h5000;
    logic [15:0]       prog_data = 16'h4444;
    cdd_pkg::cdd_req_s req       = '0;
    cdd_pkg::cdd_req_s r;
    cdd_pkg::cdd_res_s res;
    logic              ready, done, illegal, stk_we, stk_re, irq_enable, irq_service;
    logic [15:0]       stk_addr, stk_wdata, prog_addr;
    int                err_count = 0;
    int                tests_run = 0;

    always #5 ref_clk = ~ref_clk;

    cdd_exec cdd_exec_i (.ref_clk(ref_clk), .rst(rst), .start(start), .req(req), .ready(ready),
        .done(done), .illegal(illegal), .res(res), .stk_we(stk_we), .stk_re(stk_re),
        .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata), .prog_addr(prog_addr),
        .prog_data(prog_data), .irq_pend(irq_pend), .irq_enable(irq_enable), .irq_service(irq_service));

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // expected flags word: we bit, then c z s v, low bits kept from the context
    function automatic logic [8:0] fl(input logic c, input logic z, input logic s, input logic v);
        return {1'b1, c, z, s, v, 4'hf};
    endfunction

    task end_of_test;
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one instruction: strobe start, count cycles to done, check flags
    task go(input logic [7:0] op, input logic [15:0] d, input logic [7:0] s, input logic [4:0] n,
            input logic [8:0] f);
        int k;
        r.opcode = op;
        r.dst = d;
        r.src = s;
        @(posedge ref_clk);
        req <= r;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        k = 1;
        #1;
        while (done !== 1'b1 && k < 40) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk("cycles", {11'h0, n}, 16'(k));
        chk("flags", {7'h0, f}, {7'h0, f[8] ? {res.flags_we, res.flags} : {res.flags_we, 8'h00}});
    endtask

    initial begin
        #50000;
        err_count++;
        end_of_test();
    end

    initial begin
        r = '0;
        r.ctx = '{pc: 16'h1000, sp: 16'h0200, tp: 16'h3000, flags: 8'h8f};
        r.disp = 8'hfe;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        go(8'h00, 16'h0080, 8'h00, 5'd4, fl(1, 0, 0, 1));
        chk("dec8", 16'h017f, {7'h0, res.dst8_we, res.dst[7:0]});
        chk("len", 16'h0002, {14'h0, res.len});
        go(8'h01, 16'h0001, 8'h00, 5'd4, fl(1, 1, 0, 0));
        chk("dec8", 16'h0000, {8'h0, res.dst[7:0]});
        go(8'h00, 16'h0000, 8'h00, 5'd4, fl(1, 0, 1, 0));
        go(8'h80, 16'h8000, 8'h00, 5'd8, fl(1, 0, 0, 1));
        chk("dec16", 16'h7fff, res.dst);
        go(8'h81, 16'h1200, 8'h00, 5'd8, fl(1, 0, 0, 0));
        chk("dec16", 16'h11ff, res.dst);
        go(8'h81, 16'h0001, 8'h00, 5'd8, fl(1, 1, 0, 0));
        go(8'h94, 16'h1003, 8'h40, 5'd26, fl(0, 0, 0, 0));
        chk("div", 16'h0340, res.dst);
        chk("len", 16'h0003, {14'h0, res.len});
        go(8'h95, 16'h0100, 8'h02, 5'd26, fl(0, 0, 1, 0));
        chk("div", 16'h0080, res.dst);
        go(8'h96, 16'h0005, 8'h10, 5'd26, fl(0, 1, 0, 0));
        chk("div", 16'h0500, res.dst);
        go(8'h96, 16'h0300, 8'h03, 5'd26, fl(1, 0, 0, 1));
        go(8'h94, 16'hff00, 8'h01, 5'd26, fl(0, 0, 0, 1));
        go(8'h95, 16'h1234, 8'h00, 5'd10, fl(0, 1, 0, 1));
        chk("divwe", 16'h0000, {15'h0, res.dst16_we});
        go(8'h1a, 16'h0002, 8'h00, 5'd8, 9'h000);
        chk("cdb", 16'h1101, {3'h0, res.pc_we, res.wreg, res.dst[7:0]});
        chk("cdbpc", 16'h0ffe, res.pc);
        go(8'h3a, 16'h0001, 8'h00, 5'd8, 9'h000);
        chk("cdb", 16'h0300, {3'h0, res.pc_we, res.wreg, res.dst[7:0]});
        go(8'h02, 16'h0005, 8'h00, 5'd2, 9'h000);
        chk("illegal", 16'h0001, {15'h0, illegal});
        @(posedge ref_clk);
        irq_pend <= 1'b1;
        go(8'h9f, 16'h0000, 8'h00, 5'd4, 9'h000);
        chk("irqon", 16'h0003, {14'h0, irq_enable, irq_service});
        chk("len", 16'h0001, {14'h0, res.len});
        go(8'h8f, 16'h0000, 8'h00, 5'd4, 9'h000);
        chk("irqoff", 16'h0000, {14'h0, irq_enable, irq_service});
        go(8'h1f, 16'h0000, 8'h00, 5'd14, 9'h000);
        chk("pc", 16'h4444, res.pc);
        chk("tp", 16'h1002, res.tp);
        chk("sp", 16'h01fe, res.sp);
        chk("push", 16'h3000, stk_wdata);
        chk("paddr", 16'h1000, prog_addr);
        go(8'h2f, 16'h0000, 8'h00, 5'd14, 9'h000);
        chk("tp", 16'h5002, res.tp);
        chk("sp", 16'h0202, res.sp);
        chk("pop", 16'h0200, stk_addr);
        chk("paddr", 16'h5000, prog_addr);
        r.stk_ext = 1'b1;
        go(8'h2f, 16'h0000, 8'h00, 5'd16, 9'h000);
        chk("pc", 16'h4444, res.pc);
        end_of_test();
    end
endmodule
`default_nettype wire
